// >>> srh_pkg.sv
// shared constants and types for the asynchronous byte memory host controller
package srh_pkg;

	// memory geometry and step counter width
	localparam int INDEX_W = 19;
	localparam int BYTE_W  = 8;
	localparam int CNT_W   = 4;

	// clock period in picoseconds (125 MHz)
	localparam int CLK_PERIOD_PS = 8000;

	// pin timing figures in ns
	localparam int GRADE_DEFAULT_NS          = 35;
	localparam int STORE_PULSE_WIDTH_NS      = 15;
	localparam int SELECT_TO_STORE_END_NS    = 15;
	localparam int INDEX_TO_STORE_END_NS     = 15;
	localparam int DATA_TO_STORE_END_NS      = 10;
	localparam int DATA_HOLD_NS              = 0;
	localparam int STORE_RECOVERY_TIME_NS    = 0;
	localparam int DESELECT_FLOAT_DELAY_NS   = 10;
	localparam int STORE_TO_FLOAT_DELAY_NS   = 10;

	// synchroniser depth and read settling guard, in cycles
	localparam int SYNC_LAT_CYC    = 3;
	localparam int SETTLE_GUARD_CYC = 4;

	// least time in ns to whole cycles, rounded up, never below one
	function automatic int cyc_min(input int t_ns);
		int c;
		c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// store pulse covers pulse width, select overlap, index overlap and data setup
	localparam int STORE_PULSE_CYC = cyc_min(max2(max2(STORE_PULSE_WIDTH_NS, SELECT_TO_STORE_END_NS),
		max2(INDEX_TO_STORE_END_NS, DATA_TO_STORE_END_NS)));
	localparam int STORE_HOLD_CYC  = cyc_min(max2(DATA_HOLD_NS, STORE_RECOVERY_TIME_NS));
	localparam int DESELECT_FLOAT_CYC = cyc_min(DESELECT_FLOAT_DELAY_NS);
	localparam int STORE_FLOAT_CYC = cyc_min(STORE_TO_FLOAT_DELAY_NS);

	// controller states, gray coded along the read path
	typedef enum logic [2:0] {
		SRH_IDLE     = 3'h0,
		SRH_RD_ACC   = 3'h1,
		SRH_RD_CAP   = 3'h3,
		SRH_RD_FLOAT = 3'h2,
		SRH_WR_INDEX = 3'h6,
		SRH_WR_PULSE = 3'h7,
		SRH_WR_HOLD  = 3'h5
	} srh_state_type;

endpackage

// >>> srh_sync_if.sv
// bundle between the controller and its byte-line synchroniser
`timescale 1ns/1ps
interface srh_sync_if #(
	parameter int W = 8
);
	logic [W-1:0] raw;
	logic [W-1:0] stable;
	logic         settled;

	modport src (output raw, input stable, input settled);
	modport sync (input raw, output stable, output settled);
endinterface

// >>> srh_pin_sync.sv
// three-stage synchroniser for the byte lines with agreement flag
`timescale 1ns/1ps
module srh_pin_sync #(
	parameter int W = 8
) (
	input  wire logic clk,
	input  wire logic rst_b,
	srh_sync_if.sync  pins
);
	logic [W-1:0] meta_r;
	logic [W-1:0] mid_r;
	logic [W-1:0] last_r;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			mid_r  <= '0;
			last_r <= '0;
		end else begin
			meta_r <= pins.raw;
			mid_r  <= meta_r;
			last_r <= mid_r;
		end
	end

	// a value counts only once stages two and three agree
	assign pins.stable  = last_r;
	assign pins.settled = (mid_r == last_r);
endmodule // srh_pin_sync

// >>> srh_host.sv
// host controller driving an asynchronous 512K x 8 static memory over its pins
// Overview of operation
// (RULE1) memory holds 524,288 bytes, 19-bit index, 8-bit two-way byte lines
// (RULE2) a store happens while select and store strobe are both low
// (RULE3) store strobe stays high through every read
// (RULE4) index is stable no later than select falls for a read
// (RULE5) select falling with or after store strobe keeps memory lines floating
// (RULE6) store recovery counted from the first rising strobe, least zero
// (RULE7) read data valid 20, 25 or 35 ns after select or index
// (RULE8) read data valid 10 or 15 ns after output drive falls
// (RULE9) memory holds old read data 5 ns after index changes
// (RULE10) memory floats its lines within 10 ns after deselect
// (RULE11) select low at least 15 ns before store ends
// (RULE12) index stable at least 15 ns before store ends
// (RULE13) store data valid 10 ns before store end, held 0 ns after
// (RULE14) memory floats its lines within 10 ns after store strobe falls
// (RULE15) memory resumes driving no sooner than 5 ns after store end
// (RULE16) controller never drives against the memory around a store
// (RULE17) with output drive low, memory echoes the byte being written
// (RULE18) after such a store, memory shows read data of next index
// (RULE19) output drive kept high whenever the controller drives store data
`timescale 1ns/1ps
module srh_host #(
	parameter int GRADE_NS = srh_pkg::GRADE_DEFAULT_NS
) (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	// user request side
	input  wire logic                         req_valid,
	input  wire logic                         req_write,
	input  wire logic [srh_pkg::INDEX_W-1:0]  req_index,
	input  wire logic [srh_pkg::BYTE_W-1:0]   req_wdata,
	output logic                              req_ready,
	output logic                              done,
	output logic                              done_write,
	output logic [srh_pkg::BYTE_W-1:0]        rd_data,
	// memory pins
	output logic [srh_pkg::INDEX_W-1:0]       word_index,
	output logic                              sel_b,
	output logic                              drive_b,
	output logic                              store_b,
	input  wire logic [srh_pkg::BYTE_W-1:0]   byte_lines_in,
	output logic [srh_pkg::BYTE_W-1:0]        byte_lines_out,
	output logic                              byte_lines_oe
);

	// read access wait: slowest of index and select access, plus synchroniser depth
	localparam int ACC_CYC = srh_pkg::cyc_min(GRADE_NS) + srh_pkg::SYNC_LAT_CYC;

	localparam logic [srh_pkg::CNT_W-1:0] ACC_LOAD    = srh_pkg::CNT_W'(ACC_CYC - 1);
	localparam logic [srh_pkg::CNT_W-1:0] PULSE_LOAD  = srh_pkg::CNT_W'(srh_pkg::STORE_PULSE_CYC - 1);
	localparam logic [srh_pkg::CNT_W-1:0] HOLD_LOAD   = srh_pkg::CNT_W'(srh_pkg::STORE_HOLD_CYC - 1);
	localparam logic [srh_pkg::CNT_W-1:0] FLOAT_LOAD  = srh_pkg::CNT_W'(srh_pkg::DESELECT_FLOAT_CYC - 1);
	localparam logic [srh_pkg::CNT_W-1:0] GUARD_LOAD  = srh_pkg::CNT_W'(srh_pkg::SETTLE_GUARD_CYC - 1);
	localparam logic [srh_pkg::CNT_W-1:0] CNT_ZERO    = 4'h0;

	srh_pkg::srh_state_type state_r;
	srh_pkg::srh_state_type state_nxt;

	logic [srh_pkg::CNT_W-1:0]   cnt_r;
	logic [srh_pkg::CNT_W-1:0]   cnt_nxt;
	logic [srh_pkg::INDEX_W-1:0] index_r;
	logic [srh_pkg::INDEX_W-1:0] index_nxt;
	logic [srh_pkg::BYTE_W-1:0]  wdata_r;
	logic [srh_pkg::BYTE_W-1:0]  wdata_nxt;
	logic [srh_pkg::BYTE_W-1:0]  rdata_r;
	logic [srh_pkg::BYTE_W-1:0]  rdata_nxt;
	logic                        sel_b_r;
	logic                        sel_b_nxt;
	logic                        drive_b_r;
	logic                        drive_b_nxt;
	logic                        store_b_r;
	logic                        store_b_nxt;
	logic                        oe_r;
	logic                        oe_nxt;
	logic                        ready_r;
	logic                        ready_nxt;
	logic                        done_r;
	logic                        done_nxt;
	logic                        done_wr_r;
	logic                        done_wr_nxt;

	// synchronised view of the byte lines
	srh_sync_if #(.W(srh_pkg::BYTE_W)) pin_if ();

	assign pin_if.raw = byte_lines_in;

	srh_pin_sync #(
		.W     (srh_pkg::BYTE_W)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.pins  (pin_if.sync)
	);

	// decode of the current step
	wire cnt_done   = (cnt_r == CNT_ZERO);
	wire take_req   = (state_r == srh_pkg::SRH_IDLE) && req_valid;
	wire take_read  = take_req && !req_write;
	wire take_write = take_req && req_write;
	wire read_ok    = pin_if.settled || cnt_done;
	wire [srh_pkg::CNT_W-1:0] cnt_dec = cnt_done ? CNT_ZERO : cnt_r - 4'h1;

	// sequencing of the memory strobes
	always_comb begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_dec;
		index_nxt   = index_r;
		wdata_nxt   = wdata_r;
		rdata_nxt   = rdata_r;
		sel_b_nxt   = sel_b_r;
		drive_b_nxt = drive_b_r;
		store_b_nxt = 1'b1;
		oe_nxt      = oe_r;
		ready_nxt   = 1'b0;
		done_nxt    = 1'b0;
		done_wr_nxt = 1'b0;
		case (state_r)
			srh_pkg::SRH_IDLE: begin
				ready_nxt = !req_valid;
				if (take_read) begin
					// index, select and output drive change on one edge
					index_nxt   = req_index; // RULE4
					sel_b_nxt   = 1'b0;
					drive_b_nxt = 1'b0;
					store_b_nxt = 1'b1; // RULE3
					cnt_nxt     = ACC_LOAD;
					state_nxt   = srh_pkg::SRH_RD_ACC;
				end else if (take_write) begin
					// index settles a full cycle before the strobes fall
					index_nxt   = req_index;
					wdata_nxt   = req_wdata;
					state_nxt   = srh_pkg::SRH_WR_INDEX;
				end
			end
			srh_pkg::SRH_RD_ACC: begin
				// wait out index and select access plus sync depth
				if (cnt_done) begin // RULE7 RULE8
					cnt_nxt   = GUARD_LOAD;
					state_nxt = srh_pkg::SRH_RD_CAP;
				end
			end
			srh_pkg::SRH_RD_CAP: begin
				// take the byte once two stages agree, or when the guard expires
				if (read_ok) begin
					rdata_nxt   = pin_if.stable;
					sel_b_nxt   = 1'b1;
					drive_b_nxt = 1'b1;
					done_nxt    = 1'b1;
					cnt_nxt     = FLOAT_LOAD;
					state_nxt   = srh_pkg::SRH_RD_FLOAT;
				end
			end
			srh_pkg::SRH_RD_FLOAT: begin
				// memory may still drive after deselect, so hold off any write
				if (cnt_done) begin // RULE10 RULE16
					ready_nxt = 1'b1;
					state_nxt = srh_pkg::SRH_IDLE;
				end
			end
			srh_pkg::SRH_WR_INDEX: begin
				// select and store fall together, so the memory keeps its lines floating
				sel_b_nxt   = 1'b0; // RULE5
				store_b_nxt = 1'b0; // RULE2
				drive_b_nxt = 1'b1; // RULE19
				oe_nxt      = 1'b1; // RULE16
				cnt_nxt     = PULSE_LOAD;
				state_nxt   = srh_pkg::SRH_WR_PULSE;
			end
			srh_pkg::SRH_WR_PULSE: begin
				// index, select and data all stand for the whole pulse
				store_b_nxt = 1'b0;
				if (cnt_done) begin // RULE11 RULE12 RULE13
					store_b_nxt = 1'b1;
					sel_b_nxt   = 1'b1;
					cnt_nxt     = HOLD_LOAD;
					state_nxt   = srh_pkg::SRH_WR_HOLD;
				end
			end
			srh_pkg::SRH_WR_HOLD: begin
				// data and index held past both rising strobes
				if (cnt_done) begin // RULE6 RULE13
					oe_nxt      = 1'b0;
					done_nxt    = 1'b1;
					done_wr_nxt = 1'b1;
					ready_nxt   = 1'b1;
					state_nxt   = srh_pkg::SRH_IDLE;
				end
			end
			default: begin
				sel_b_nxt   = 1'b1;
				drive_b_nxt = 1'b1;
				oe_nxt      = 1'b0;
				state_nxt   = srh_pkg::SRH_IDLE;
			end
		endcase
	end

	// state, counter, index and data registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r   <= srh_pkg::SRH_IDLE;
			cnt_r     <= CNT_ZERO;
			index_r   <= '0;
			wdata_r   <= '0;
			rdata_r   <= '0;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			index_r   <= index_nxt;
			wdata_r   <= wdata_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// pin strobes reset high and deselected, output enable and handshake low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_b_r   <= 1'b1;
			drive_b_r <= 1'b1;
			store_b_r <= 1'b1;
			oe_r      <= 1'b0;
			ready_r   <= 1'b0;
			done_r    <= 1'b0;
			done_wr_r <= 1'b0;
		end else begin
			sel_b_r   <= sel_b_nxt;
			drive_b_r <= drive_b_nxt;
			store_b_r <= store_b_nxt;
			oe_r      <= oe_nxt;
			ready_r   <= ready_nxt;
			done_r    <= done_nxt;
			done_wr_r <= done_wr_nxt;
		end
	end

	// every output straight from a flop
	assign word_index     = index_r; // RULE1
	assign sel_b          = sel_b_r;
	assign drive_b        = drive_b_r;
	assign store_b        = store_b_r;
	assign byte_lines_out = wdata_r;
	assign byte_lines_oe  = oe_r;
	assign req_ready      = ready_r;
	assign done           = done_r;
	assign done_write     = done_wr_r;
	assign rd_data        = rdata_r;

endmodule // srh_host

// >>> srh_host_props.sv
// pin timing checker for the byte memory host controller
`timescale 1ns/1ps
module srh_host_props (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        done,
	input wire logic        done_write,
	input wire logic [18:0] word_index,
	input wire logic        sel_b,
	input wire logic        drive_b,
	input wire logic        store_b,
	input wire logic [7:0]  byte_lines_out,
	input wire logic        byte_lines_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// two selected store cycles with index and data held, then the strobe rises
	sequence s_pulse;
		(!store_b && !sel_b && byte_lines_oe && $stable(word_index) && $stable(byte_lines_out))[*2] ##1 store_b;
	endsequence

	a_store_pulse: assert property ($fell(store_b) |-> s_pulse)
		else $error("store pulse too short or unstable");
	a_store_hold: assert property ($rose(store_b) |-> byte_lines_oe && $stable(byte_lines_out))
		else $error("store data dropped at strobe rise");
	a_store_done: assert property ($rose(store_b) |=> done && done_write)
		else $error("store did not finish after strobe rise");
	a_strobe_pair: assert property ($fell(store_b) |-> $fell(sel_b))
		else $error("select fell apart from store strobe");
	a_read_nostore: assert property (!sel_b && !drive_b |-> store_b)
		else $error("store strobe low during read");
	a_index_stable: assert property (!sel_b && !$past(sel_b) |-> $stable(word_index))
		else $error("index moved while selected");
	a_no_clash: assert property (byte_lines_oe |-> drive_b)
		else $error("controller drives while memory may drive");
	a_read_access: assert property ($fell(sel_b) && store_b |-> !sel_b[*5])
		else $error("read select shorter than access time");
	a_read_float: assert property (done && !done_write |-> sel_b[*3])
		else $error("reselect before lines float");
endmodule // srh_host_props

bind srh_host srh_host_props u_props (
	.clk,
	.rst_b,
	.done,
	.done_write,
	.word_index,
	.sel_b,
	.drive_b,
	.store_b,
	.byte_lines_out,
	.byte_lines_oe
);

// >>> srh_mem_model.sv
// behavioural byte memory answering the host pins
`timescale 1ns/1ps
module srh_mem_model #(
	parameter int ACC_NS = 35
) (
	input  wire logic [18:0] word_index,
	input  wire logic        sel_b,
	input  wire logic        drive_b,
	input  wire logic        store_b,
	input  wire logic [7:0]  bus,
	output logic      [7:0]  dq,
	output logic             oe_m
);
	logic [7:0]  mem [0:19'h7FFFF];
	logic [18:0] idx_d;
	logic [7:0]  last_q = 8'h00;
	wire         rd = !sel_b && !drive_b && store_b;
	wire         wr = !sel_b && !store_b;
	// drive held low through a store echoes the byte being written; the host never does this
	wire         echo = wr && !drive_b;

	// old data lingers briefly after the index moves
	assign #5 idx_d = word_index;

	// byte taken when either strobe ends the overlap
	always @(negedge wr)
		mem[word_index] = bus;

	// drive only after the full access delay, release at once
	initial oe_m = 1'h0;
	always @(posedge rd) begin
		#(ACC_NS);
		oe_m = rd;
	end
	always @(negedge rd)
		oe_m = 1'h0;

	// released lines show the inverse, so a stale byte never passes
	always @(negedge oe_m)
		last_q = mem[idx_d];
	assign dq = oe_m ? mem[idx_d] : echo ? bus : ~last_q;
endmodule // srh_mem_model

// >>> srh_host_tb.sv
// self-checking bench for the byte memory host controller
`timescale 1ns/1ps
module srh_host_tb;
	logic        clk;
	logic        rst_b;
	logic        req_valid;
	logic        req_write;
	logic [18:0] req_index;
	logic [7:0]  req_wdata;
	logic        req_ready;
	logic        done;
	logic        done_write;
	logic [7:0]  rd_data;
	logic [18:0] word_index;
	logic        sel_b;
	logic        drive_b;
	logic        store_b;
	logic [7:0]  lines_out;
	logic        lines_oe;
	logic [7:0]  dq;
	logic        mem_oe;
	wire  [7:0]  bus;
	int          errors;
	int          samples_checked;

	// wire level: controller when enabled, else the memory side
	assign bus = lines_oe ? lines_out : dq;

	srh_host #(.GRADE_NS(35)) uut (
		.clk(clk),
		.rst_b(rst_b),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_index(req_index),
		.req_wdata(req_wdata),
		.req_ready(req_ready),
		.done(done),
		.done_write(done_write),
		.rd_data(rd_data),
		.word_index(word_index),
		.sel_b(sel_b),
		.drive_b(drive_b),
		.store_b(store_b),
		.byte_lines_in(bus),
		.byte_lines_out(lines_out),
		.byte_lines_oe(lines_oe)
	);

	srh_mem_model #(.ACC_NS(35)) u_mem (
		.word_index(word_index),
		.sel_b(sel_b),
		.drive_b(drive_b),
		.store_b(store_b),
		.bus(bus),
		.dq(dq),
		.oe_m(mem_oe)
	);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic test_done;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one request, held for the take edge only, then bounded wait for done
	task automatic op(input logic wr, input logic [18:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'h1 && n < 50);
		// a controller that never goes idle is a failure, not a silent request
		if (req_ready !== 1'h1) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, req_ready, 1'h1);
			test_done();
		end
		req_valid <= 1'h1;
		req_write <= wr;
		req_index <= idx;
		req_wdata <= wd;
		@(posedge clk);
		req_valid <= 1'h0;
		do begin
			@(posedge clk);
			n++;
		end while (done !== 1'h1 && n < 100);
		if (done !== 1'h1) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, done, 1'h1);
			test_done();
		end
		chk(done_write, wr);
		chk(word_index, idx);
		if (wr)
			chk(lines_out, wd);
	endtask

	// reset drives every strobe idle and clears the read byte
	task automatic t_reset;
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (5) @(posedge clk);
		chk({sel_b, drive_b, store_b, lines_oe, done, req_ready}, 6'h38);
		chk(rd_data, 8'h00);
		chk(word_index, 19'h00000);
		chk(lines_out, 8'h00);
		rst_b <= 1'h1;
	endtask

	// lowest and highest index keep separate bytes
	task automatic t_edges;
		op(1'h1, 19'h00000, 8'hA5);
		op(1'h1, 19'h7FFFF, 8'h5A);
		op(1'h0, 19'h00000, 8'h00);
		chk(rd_data, 8'hA5);
		op(1'h0, 19'h7FFFF, 8'h00);
		chk(rd_data, 8'h5A);
	endtask

	// second store wins, back-to-back reads follow the index
	task automatic t_overwrite;
		op(1'h1, 19'h12345, 8'h3C);
		op(1'h1, 19'h12345, 8'hC3);
		op(1'h0, 19'h12345, 8'h00);
		chk(rd_data, 8'hC3);
		op(1'h0, 19'h00000, 8'h00);
		chk(rd_data, 8'hA5);
	endtask

	// reset mid-run clears the controller, memory keeps its bytes
	task automatic t_mid_reset;
		t_reset();
		op(1'h0, 19'h12345, 8'h00);
		chk(rd_data, 8'hC3);
	endtask

	initial begin
		rst_b = 1'h0;
		req_valid = 1'h0;
		req_write = 1'h0;
		req_index = 19'h00000;
		req_wdata = 8'h00;
		errors = 0;
		samples_checked = 0;
		t_reset();
		t_edges();
		t_overwrite();
		t_mid_reset();
		test_done();
	end
endmodule // srh_host_tb
